// *** core/qmr_outputs.sv ***
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Each of four channels has its own active-low terminal-ready output.
// - Writing one to modem-control bit 0 drives terminal-ready low.
// - Writing zero to modem-control bit 0, or any reset, drives it high.
// - Terminal-ready level never affects transmitter or receiver operation.
// - In the default bus mode each channel has an active-high interrupt output.
// - Channel interrupt needs bit 3 enable or select high, enabled source and present condition.
// - Sources: receiver error, receive data, transmit empty, modem status change.
// - In the alternate bus mode channel interrupt pins are released.
// - Select input high enables outputs in the default bus mode; low lets bit 3 decide.
// - Alternate bus mode merges all channels into one active-low wired-OR request.
// - Reset returns every register and output to its reset state.
module qmr_outputs
  import qmr_pkg::*;
(
  // Clock and reset.
  input  wire  logic                           clk_i,
  input  wire  logic                           rst_i,
  // Wishbone slave.
  input  wire  logic                           cyc_i,
  input  wire  logic                           stb_i,
  input  wire  logic                           we_i,
  input  wire  logic [7:2]                     adr_i,
  input  wire  logic [3:0]                     sel_i,
  input  wire  logic [31:0]                    dat_i,
  output logic [31:0]                          dat_o,
  output logic                                 ack_o,
  // Device pins and conditions from the channel logic.
  input  wire  logic                           irq_output_select_i,
  input  wire  logic                           bus_mode_alt_i,
  input  wire  logic [NUM_CHAN-1:0][SRC_W-1:0] irq_cond_i,
  // Modem and interrupt pins.
  output logic [NUM_CHAN-1:0]                  term_ready_n_o,
  output logic [NUM_CHAN-1:0]                  chan_irq_o,
  output logic [NUM_CHAN-1:0]                  chan_irq_oe_o,
  output logic                                 shared_irq_n_o,
  output logic                                 shared_irq_oe_o,
  // Event interrupt.
  output logic                                 irq_o
);

  qmr_state_t q_reg;
  qmr_state_t q_next;

  logic [7:0]          byte_adr;
  logic                bus_req;
  logic                wr_stb;
  logic                rd_stb;
  logic [NUM_CHAN-1:0] pend;
  logic [NUM_CHAN-1:0] gate;

  // Decodes one per-channel register bank; used for both banks.
  function automatic logic bank_hit(input logic [7:0] adr, input logic [7:0] base);
    bank_hit = (adr[7:4] == base[7:4]);
  endfunction

  // Bus strobes: a write lands and a read clears on the acknowledging edge.
  assign byte_adr = {adr_i, 2'b00};
  assign bus_req  = cyc_i & stb_i;
  assign wr_stb   = bus_req & q_reg.ack & we_i & sel_i[0];
  assign rd_stb   = bus_req & q_reg.ack & ~we_i;

  // Per-channel pending and output gating.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
      assign pend[gi] = |(q_reg.irq_enable[gi] & irq_cond_i[gi]);
      assign gate[gi] = q_reg.sel_s2 | q_reg.modem_ctrl[gi][MC_IRQ_OUT_EN];
    end
  endgenerate

  // Next-state logic for the whole block.
  always_comb begin
    q_next = q_reg;
    // Pins come from outside the clock domain; only the second stage is read.
    q_next.sel_s1 = irq_output_select_i;
    q_next.sel_s2 = q_reg.sel_s1;
    q_next.alt_s1 = bus_mode_alt_i;
    q_next.alt_s2 = q_reg.alt_s1;
    // Acknowledge one cycle after the request, then drop for a cycle.
    q_next.ack   = bus_req & ~q_reg.ack;
    // Read data is zero outside the answering cycle, so a stray sample reads nothing.
    q_next.rdata = 32'h0000_0000;
    if (bus_req && !q_reg.ack && !we_i) begin
      if (bank_hit(byte_adr, OFS_MODEM_CTRL)) begin
        q_next.rdata[7:0] = q_reg.modem_ctrl[byte_adr[3:2]];
      end else if (bank_hit(byte_adr, OFS_IRQ_ENABLE)) begin
        q_next.rdata[SRC_W-1:0] = q_reg.irq_enable[byte_adr[3:2]];
      end else if (byte_adr == OFS_EVT_STATUS) begin
        q_next.rdata[NUM_CHAN-1:0] = q_reg.evt_status;
      end else if (byte_adr == OFS_EVT_MASK) begin
        q_next.rdata[NUM_CHAN-1:0] = q_reg.evt_mask;
      end else if (byte_adr == OFS_LINE_STATE) begin
        q_next.rdata[11:0] = {q_reg.alt_s2, q_reg.sel_s2, 2'b00, pend, q_reg.term_ready_n};
      end
    end
    // Register writes; unmapped writes are acknowledged and dropped.
    if (wr_stb) begin
      if (bank_hit(byte_adr, OFS_MODEM_CTRL)) begin
        q_next.modem_ctrl[byte_adr[3:2]] = dat_i[7:0];
      end else if (bank_hit(byte_adr, OFS_IRQ_ENABLE)) begin
        q_next.irq_enable[byte_adr[3:2]] = dat_i[SRC_W-1:0];
      end else if (byte_adr == OFS_EVT_MASK) begin
        q_next.evt_mask = dat_i[NUM_CHAN-1:0];
      end
    end
    // Sticky events on a new pending cause; a set in the clearing read wins.
    q_next.pend_prev = pend;
    if (rd_stb && byte_adr == OFS_EVT_STATUS) begin
      q_next.evt_status = EVT_RST;
    end
    q_next.evt_status = q_next.evt_status | (pend & ~q_reg.pend_prev);
    q_next.evt_irq    = |(q_next.evt_status & q_next.evt_mask);
    // Taken from the next state so the pin moves on the edge at which the write lands.
    // Terminal-ready follows bit 0, inverted.
    // Nothing in the serial path reads this level.
    q_next.term_ready_n = ~{q_next.modem_ctrl[3][MC_TERM_READY],
                            q_next.modem_ctrl[2][MC_TERM_READY],
                            q_next.modem_ctrl[1][MC_TERM_READY],
                            q_next.modem_ctrl[0][MC_TERM_READY]};
    // Released pins also carry zero, so a later mode change starts from a known level.
    // Channel pins driven only in the default bus mode.
    q_next.chan_irq_oe = q_reg.alt_s2 ? '0 : gate;
    q_next.chan_irq    = q_reg.alt_s2 ? '0 : (gate & pend);
    // Bit 3 does not gate the shared request; that gate belongs to the default mode.
    // Wired-OR request pulls low while any channel is pending.
    q_next.shared_irq_oe = q_reg.alt_s2 & (|pend);
  end

  // State register with synchronous reset.
  // A synchronous reset cannot clear the registers on a glitch between edges.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Every register and output back to reset.
      q_reg              <= '0;
      q_reg.modem_ctrl   <= {NUM_CHAN{MODEM_CTRL_RST}};
      q_reg.irq_enable   <= {NUM_CHAN{IRQ_ENABLE_RST}};
      q_reg.term_ready_n <= '1;
    end else begin
      q_reg <= q_next;
    end
  end

  // Outputs straight from flip-flops, except the constant shared_irq_n_o.
  assign dat_o           = q_reg.rdata;
  assign ack_o           = q_reg.ack;
  assign term_ready_n_o  = q_reg.term_ready_n;
  assign chan_irq_o      = q_reg.chan_irq;
  assign chan_irq_oe_o   = q_reg.chan_irq_oe;
  assign shared_irq_n_o  = 1'b0; // Open drain: only the enable moves.
  assign shared_irq_oe_o = q_reg.shared_irq_oe;
  assign irq_o           = q_reg.evt_irq;

  // Checks on the outputs this block drives and on its event status register.
  // All checks share the one clock; all but AST_TR_RESET are off while reset is high.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wr_ch0_mc(logic bitval);
    cyc_i && stb_i && ack_o && we_i && sel_i[0] && byte_adr == OFS_MODEM_CTRL
      && dat_i[MC_TERM_READY] == bitval;
  endsequence

  AST_TR_LOW: assert property (s_wr_ch0_mc(1'b1) |=> !term_ready_n_o[0])
    else $error("Terminal-ready did not go low after enable write.");

  AST_TR_HIGH: assert property (s_wr_ch0_mc(1'b0) |=> term_ready_n_o[0])
    else $error("Terminal-ready did not go high after disable write.");

  AST_TR_RESET: assert property (@(posedge clk_i) disable iff (1'b0)
      rst_i |=> term_ready_n_o == '1 && chan_irq_o == '0 && !ack_o)
    else $error("Outputs not at reset state after reset.");

  AST_TR_STABLE: assert property (!(cyc_i && stb_i && we_i) ##1 !(cyc_i && stb_i && we_i)
      |-> $stable(term_ready_n_o))
    else $error("Terminal-ready moved without a write.");

  AST_IRQ_CAUSE: assert property (chan_irq_o[0] |-> $past(pend[0]) && $past(gate[0])
      && !$past(q_reg.alt_s2))
    else $error("Channel interrupt without enable and pending cause.");

  AST_IRQ_DROP: assert property (!pend[0] |=> !chan_irq_o[0])
    else $error("Channel interrupt stayed high with nothing pending.");

  AST_SEL_FORCE: assert property (q_reg.sel_s2 && !q_reg.alt_s2 |=> chan_irq_oe_o == '1)
    else $error("Select high did not enable every channel output.");

  AST_ALT_RELEASE: assert property (q_reg.alt_s2 |=> chan_irq_oe_o == '0)
    else $error("Channel pins driven in the alternate bus mode.");

  AST_SHARED_IRQ: assert property (q_reg.alt_s2 && (|pend) |=> shared_irq_oe_o)
    else $error("Shared request not pulled low while a channel pends.");

  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("Acknowledge held longer than one cycle.");

  // Any request not yet answered; the slave has no wait states to add.
  sequence s_bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence

  // A read request that the slave has not yet answered.
  sequence s_rd_req;
    cyc_i && stb_i && !we_i && !ack_o;
  endsequence

  // The answering edge of a status read, with no new cause arriving in it.
  sequence s_status_clear;
    cyc_i && stb_i && !we_i && ack_o && byte_adr == OFS_EVT_STATUS
      && (pend & ~q_reg.pend_prev) == '0;
  endsequence

  // A write to one channel's modem-control word, with the terminal-ready bit given.
  sequence s_wr_mc_ch(int ch, logic bitval);
    cyc_i && stb_i && ack_o && we_i && sel_i[0]
      && byte_adr == 8'(OFS_MODEM_CTRL + 4 * ch) && dat_i[MC_TERM_READY] == bitval;
  endsequence

  // Every access answered.
  // A request is answered on the next edge, mapped or not, so a master never hangs.
  AST_ACK_ANSWER: assert property (s_bus_req |=> ack_o)
    else $error("Request not acknowledged on the next cycle.");

  // Read data width.
  // Only the low twelve bits carry fields; the rest must read zero.
  AST_RD_UPPER: assert property (s_rd_req |=> ack_o && dat_o[31:12] == '0)
    else $error("Read data upper bits not zero.");

  AST_DAT_IDLE: assert property (!ack_o |-> dat_o == '0)
    else $error("Read data present without acknowledge.");

  AST_EVT_CLEAR: assert property (s_status_clear |=> q_reg.evt_status == '0)
    else $error("Event status not cleared by its read.");

  // Byte lane refused.
  // A write without the low byte lane must not move any field; all of them live there.
  AST_WR_NO_LANE: assert property (cyc_i && stb_i && ack_o && we_i && !sel_i[0]
      |=> $stable(term_ready_n_o))
    else $error("Write without the low byte lane changed terminal-ready.");

  AST_LINE_READY: assert property (s_rd_req ##0 byte_adr == OFS_LINE_STATE
      |=> dat_o[3:0] == term_ready_n_o)
    else $error("Line state read does not show terminal-ready.");

  AST_ALT_CHAN_LOW: assert property (q_reg.alt_s2 |=> chan_irq_o == '0)
    else $error("Channel interrupt level driven in the alternate bus mode.");

  // Shared request idle.
  // In the default mode the shared line must stay released, or it would fight the channels.
  AST_SHARED_IDLE: assert property (!q_reg.alt_s2 |=> !shared_irq_oe_o)
    else $error("Shared request driven in the default bus mode.");

  AST_SHARED_DROP: assert property (q_reg.alt_s2 && !(|pend) |=> !shared_irq_oe_o)
    else $error("Shared request held with nothing pending.");

  // Per-channel checks; one copy per channel so a fault names its channel.
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chk
      AST_TR_CH_LOW: assert property (s_wr_mc_ch(gi, 1'b1) |=> !term_ready_n_o[gi])
        else $error("Channel terminal-ready did not go low after enable write.");
      AST_TR_CH_HIGH: assert property (s_wr_mc_ch(gi, 1'b0) |=> term_ready_n_o[gi])
        else $error("Channel terminal-ready did not go high after disable write.");
      AST_IRQ_OE_FOLLOW: assert property (!q_reg.alt_s2
          |=> chan_irq_oe_o[gi] == $past(gate[gi]))
        else $error("Channel drive enable does not follow select and bit 3.");
      AST_IRQ_OE_BIT3: assert property (!q_reg.sel_s2 && !q_reg.alt_s2
          |=> chan_irq_oe_o[gi] == $past(q_reg.modem_ctrl[gi][MC_IRQ_OUT_EN]))
        else $error("Channel drive enable does not follow bit 3 with select low.");
      AST_IRQ_RAISE: assert property (!q_reg.alt_s2 && gate[gi] && pend[gi]
          |=> chan_irq_o[gi] && chan_irq_oe_o[gi])
        else $error("Channel interrupt missing with an enabled pending cause.");
      AST_IRQ_CH_CAUSE: assert property (chan_irq_o[gi]
          |-> $past(pend[gi]) && $past(gate[gi]) && !$past(q_reg.alt_s2))
        else $error("Channel interrupt without enable and pending cause.");
      AST_IRQ_CH_DROP: assert property (!pend[gi] |=> !chan_irq_o[gi])
        else $error("Channel interrupt stayed high with nothing pending.");
      AST_EVT_SET: assert property (pend[gi] && !q_reg.pend_prev[gi]
          |=> q_reg.evt_status[gi])
        else $error("New pending cause not recorded in event status.");
    end
  endgenerate

endmodule // qmr_outputs

`default_nettype wire

// *** core/qmr_pkg.sv ***
package qmr_pkg;

  // Channel count and register widths.
  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned SRC_W    = 4;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_MODEM_CTRL = 8'h00; // Channels 0..3 at 0x00..0x0c.
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10; // Channels 0..3 at 0x10..0x1c.
  localparam logic [7:0] OFS_EVT_STATUS = 8'h20;
  localparam logic [7:0] OFS_EVT_MASK   = 8'h24;
  localparam logic [7:0] OFS_LINE_STATE = 8'h28;

  // Modem-control field positions.
  localparam int unsigned MC_TERM_READY = 0;
  localparam int unsigned MC_IRQ_OUT_EN = 3;

  // Interrupt source positions, shared by enable register and condition inputs.
  localparam int unsigned SRC_RX_DATA   = 0;
  localparam int unsigned SRC_TX_EMPTY  = 1;
  localparam int unsigned SRC_RX_ERROR  = 2;
  localparam int unsigned SRC_MODEM_CHG = 3;

  // Reset values.
  localparam logic [7:0]       MODEM_CTRL_RST = 8'h00;
  localparam logic [SRC_W-1:0] IRQ_ENABLE_RST = 4'h0;
  localparam logic [3:0]       EVT_RST        = 4'h0;

  // Whole state of the output block.
  typedef struct packed {
    logic [NUM_CHAN-1:0][7:0]       modem_ctrl;
    logic [NUM_CHAN-1:0][SRC_W-1:0] irq_enable;
    logic [NUM_CHAN-1:0]            evt_status;
    logic [NUM_CHAN-1:0]            evt_mask;
    logic [NUM_CHAN-1:0]            pend_prev;
    logic                           sel_s1;
    logic                           sel_s2;
    logic                           alt_s1;
    logic                           alt_s2;
    logic                           ack;
    logic [31:0]                    rdata;
    logic [NUM_CHAN-1:0]            term_ready_n;
    logic [NUM_CHAN-1:0]            chan_irq;
    logic [NUM_CHAN-1:0]            chan_irq_oe;
    logic                           shared_irq_oe;
    logic                           evt_irq;
  } qmr_state_t;

endpackage

// *** verif/qmr_far_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// Host-side view of the interrupt wires, resolved from every driver's enable.
module qmr_far_model
  import qmr_pkg::*;
(
  // Clock.
  input  wire logic                clk_i,
  // Design pin drivers.
  input  wire logic [NUM_CHAN-1:0] chan_irq_i,
  input  wire logic [NUM_CHAN-1:0] chan_oe_i,
  input  wire logic                shared_oe_i,
  // Resolved wire levels.
  output logic      [NUM_CHAN-1:0] chan_wire_o,
  output logic                     shared_wire_o
);
  logic [NUM_CHAN-1:0] last_reg = 4'h0;

  // A released channel line floats; the host sees the inverse of its last driven level.
  always_ff @(posedge clk_i) begin
    last_reg <= (chan_oe_i & chan_irq_i) | (~chan_oe_i & last_reg);
  end
  assign chan_wire_o = (chan_oe_i & chan_irq_i) | (~chan_oe_i & ~last_reg);
  assign shared_wire_o = ~shared_oe_i;
endmodule // qmr_far_model

`default_nettype wire

// *** verif/qmr_outputs_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module qmr_outputs_tb;
  import qmr_pkg::*;
  logic                           clk_i = 1'b0;
  logic                           rst_i = 1'b1;
  logic                           cyc   = 1'b0;
  logic                           stb   = 1'b0;
  logic                           we    = 1'b0;
  logic                           isel  = 1'b0;
  logic                           alt   = 1'b0;
  logic [5:0]                     adr   = 6'h00;
  logic [3:0]                     sel   = 4'h0;
  logic [31:0]                    wdat  = 32'h0;
  logic [31:0]                    rdat;
  logic [NUM_CHAN-1:0][SRC_W-1:0] cond  = '0;
  logic [31:0]                    dat_o;
  logic                           ack_o, shared_irq_n_o, shared_oe, irq_o, shared_wire;
  logic [NUM_CHAN-1:0]            term_n, chan_irq, chan_oe, chan_wire;
  int                             error_cnt = 0;
  int                             tests_run = 0;

  qmr_outputs i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .irq_output_select_i(isel), .bus_mode_alt_i(alt), .irq_cond_i(cond),
    .term_ready_n_o(term_n), .chan_irq_o(chan_irq), .chan_irq_oe_o(chan_oe),
    .shared_irq_n_o(shared_irq_n_o), .shared_irq_oe_o(shared_oe), .irq_o(irq_o));
  qmr_far_model i_far (.clk_i(clk_i), .chan_irq_i(chan_irq), .chan_oe_i(chan_oe),
    .shared_oe_i(shared_oe), .chan_wire_o(chan_wire), .shared_wire_o(shared_wire));

  // Free-running clock, 8 ns period.
  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // One classic Wishbone cycle; only the watchdog ends a wait for the answer.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a[7:2]; wdat <= d; sel <= s;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  // Pins pass two sync flops plus one output register; the fourth edge sees it settled.
  task automatic settle();
    repeat (4) @(posedge clk_i);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic t_ready();
    for (int k = 0; k < NUM_CHAN; k++) begin
      wb(1'b1, 8'(OFS_MODEM_CTRL + 4 * k), 32'h1); settle();
      chk("term_ready", 4'hf & ~(4'h1 << k), term_n);
      wb(1'b1, 8'(OFS_MODEM_CTRL + 4 * k), 32'h0); settle();
      chk("term_ready", 4'hf, term_n);
    end
    wb(1'b1, OFS_MODEM_CTRL, 32'h1, 4'he); settle();
    chk("term_ready", 4'hf, term_n);
    wb(1'b1, OFS_MODEM_CTRL, 32'h1);
    @(posedge clk_i); rst_i <= 1'b1; repeat (2) @(posedge clk_i); rst_i <= 1'b0; settle();
    chk("term_ready", 4'hf, term_n);
    $display("test t_ready done");
  endtask

  task automatic t_irq();
    for (int k = 0; k < NUM_CHAN; k++) begin
      wb(1'b1, 8'(OFS_MODEM_CTRL + 4 * k), 32'h8);
      for (int s = 0; s < SRC_W; s++) begin
        wb(1'b1, 8'(OFS_IRQ_ENABLE + 4 * k), 32'h1 << s);
        cond[k] <= ~(4'h1 << s); settle();
        chk("chan_irq", 4'h0, chan_irq);
        cond[k] <= 4'h1 << s; settle();
        chk("chan_oe", 4'h1 << k, chan_oe);
        chk("chan_irq", 4'h1 << k, chan_wire & chan_oe);
        cond[k] <= 4'h0; settle();
        chk("chan_irq", 4'h0, chan_irq);
      end
      wb(1'b1, 8'(OFS_MODEM_CTRL + 4 * k), 32'h0);
    end
    cond[0] <= 4'h8; settle();
    chk("chan_oe", 4'h0, chan_oe);
    isel <= 1'b1; settle();
    chk("chan_oe", 4'hf, chan_oe);
    chk("chan_irq", 4'h1, chan_irq);
    alt <= 1'b1; settle();
    chk("chan_oe", 4'h0, chan_oe);
    chk("shared_wire", 1'b0, shared_wire);
    chk("shared_irq_n", 1'b0, shared_irq_n_o);
    cond[0] <= 4'h0; settle();
    chk("shared_wire", 1'b1, shared_wire);
    alt <= 1'b0; isel <= 1'b0;
    $display("test t_irq done");
  endtask

  task automatic t_event();
    wb(1'b0, OFS_EVT_STATUS, 32'h0);
    chk("evt_status", 32'hf, rdat);
    wb(1'b1, OFS_IRQ_ENABLE, 32'h1);
    wb(1'b1, OFS_EVT_MASK, 32'h1);
    wb(1'b1, OFS_MODEM_CTRL, 32'h8);
    cond[0] <= 4'h1; settle();
    chk("irq_o", 1'b1, irq_o);
    wb(1'b0, OFS_EVT_STATUS, 32'h0);
    chk("evt_status", 32'h1, rdat);
    settle();
    chk("irq_o", 1'b0, irq_o);
    wb(1'b0, OFS_EVT_STATUS, 32'h0);
    chk("evt_status", 32'h0, rdat);
    wb(1'b0, 8'h3c, 32'h0);
    chk("unmapped", 32'h0, rdat);
    wb(1'b0, OFS_LINE_STATE, 32'h0);
    chk("line_state", 32'h1f, rdat & 32'hff);
    $display("test t_event done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence after a twenty-cycle reset.
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    chk("term_ready", 4'hf, term_n);
    chk("chan_oe", 4'h0, chan_oe);
    t_ready();
    t_irq();
    t_event();
    print_verdict();
  end

  // The tests need about four hundred cycles; twenty thousand means a hang.
  initial begin
    #160000;
    error_cnt++;
    print_verdict();
  end
endmodule // qmr_outputs_tb

`default_nettype wire
